/* dv/tcdma_bus_model.sv */
module tcdma_bus_model (
    input  wire logic                    clock,
    input  tcdma_pkg::tcdma_mem_req_type mem_req,
    output logic [7:0]                   mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_q = 8'h00;
    // Byte in the read cycle, changing junk otherwise
    always_comb begin
        if (mem_req.rd) begin
            mem_rdata = mem_req.addr[7:0] ^ mem_req.addr[15:8];
        end else begin
            mem_rdata = ~last_q;
        end
    end
    always_ff @(posedge clock) begin
        last_q <= mem_rdata;
    end
endmodule

/* dv/tcdma_tb.sv */
`include "tcdma_map.svh"
module tcdma_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] M1 = `TCDMA_IDX_MODE1;
    localparam logic [7:0] M2 = `TCDMA_IDX_MODE2;
    localparam logic [7:0] SR = `TCDMA_IDX_SRC;
    logic                         clock = 1'b0;
    logic                         resetn = 1'b0;
    logic [9:0]                   avs_address = '0;
    logic                         avs_read = 1'b0;
    logic                         avs_write = 1'b0;
    logic [31:0]                  avs_writedata = '0;
    logic [31:0]                  avs_readdata;
    logic                         avs_waitrequest;
    tcdma_pkg::tcdma_src_type     req_ch0 = '0;
    tcdma_pkg::tcdma_src_type     req_ch1 = '0;
    tcdma_pkg::tcdma_cpu_type     cpu = '0;
    logic [7:0]                   mem_rdata;
    tcdma_pkg::tcdma_mem_req_type mem_req;
    logic                         cpu_hold;
    int                           miscompares = 0;
    int                           compares = 0;
    integer                       seed = 32'h224C;
    logic [23:0]                  exp_wr[$];
    logic [63:0]                  exp_rd[$];
    logic [23:0]                  e_wr;
    logic [63:0]                  e_rd;
    logic [15:0]                  s[2];
    logic [15:0]                  d[2];
    logic [7:0]                   modes[6] = '{8'h0A, 8'h0F, 8'h00, 8'h02, 8'h08, 8'h0D};

    tcdma uut (.clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .req_ch0(req_ch0),
        .req_ch1(req_ch1), .cpu(cpu), .mem_rdata(mem_rdata), .mem_req(mem_req), .cpu_hold(cpu_hold));
    tcdma_bus_model bus_model (.clock(clock), .mem_req(mem_req), .mem_rdata(mem_rdata));

    always #2.5 clock = ~clock;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] data);
        int n;
        @(posedge clock);
        avs_address <= {idx, 2'b00};
        avs_writedata <= data;
        avs_write <= w;
        avs_read <= !w;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 20) begin
            check("waitrequest", 1, 0);
            results();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] data);
        bus(1'b1, idx, data);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] mask);
        exp_rd.push_back({mask, exp});
        bus(1'b0, idx, 32'h0);
    endtask
    task automatic drain();
        for (int n = 0; n < 300 && exp_wr.size() != 0; n++) @(posedge clock);
        if (exp_wr.size() != 0) begin
            check("pending transfers", 1, 0);
            results();
        end
        repeat (4) @(posedge clock);
    endtask
    function automatic logic [15:0] step(input logic [15:0] a, input logic en, input logic dec);
        return en ? (dec ? a - 16'h1 : a + 16'h1) : a;
    endfunction
    task automatic pairs(input int ch, input int n, input logic [7:0] m);
        repeat (n) begin
            exp_wr.push_back({d[ch], s[ch][7:0] ^ s[ch][15:8]});
            s[ch] = step(s[ch], m[1], m[0]);
            d[ch] = step(d[ch], m[3], m[2]);
        end
    endtask
    task automatic cfg(input int ch, input logic [15:0] sa, input logic [15:0] da, input logic [15:0] c,
                       input logic [7:0] m);
        wr(`TCDMA_IDX_SEL, ch);
        wr(M1, m);
        wr(SR, sa);
        wr(`TCDMA_IDX_DST, da);
        wr(`TCDMA_IDX_CNT, c);
        s[ch] = sa;
        d[ch] = da;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Scoreboard on register reads and bus writes
    always @(negedge clock) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            e_rd = exp_rd.size() != 0 ? exp_rd.pop_front() : 64'h0000_0000_FFFF_FFFF;
            check("readdata", avs_readdata & e_rd[63:32], e_rd[31:0]);
        end
        if (mem_req.wr === 1'b1) begin
            e_wr = exp_wr.size() != 0 ? exp_wr.pop_front() : 24'hXXXXXX;
            check("bus write", {cpu_hold, mem_req.addr, mem_req.wdata}, {1'b1, e_wr});
        end
    end

    initial begin
        idle(3);
        resetn <= 1'b1;
        for (int c = 0; c < 2; c++) begin
            wr(`TCDMA_IDX_SEL, c);
            rd(M1, 32'h0, 32'hFF);
            rd(M2, 32'h0, 32'hFF);
        end
        rd(8'h50, 32'h0, 32'hFFFFFFFF);
        foreach (modes[i]) begin
            cfg(0, 16'($random(seed)), 16'($random(seed)), 16'h00FF, modes[i]);
            pairs(0, 2, modes[i]);
            wr(M2, 8'h90);
            wr(M2, 8'h90);
            drain();
        end
        rd(M2, 32'h80, 32'hFF);
        cfg(1, 16'h3000, 16'h4000, 16'h0002, 8'hAA);
        pairs(1, 3, 8'hAA);
        wr(M2, 8'h90);
        drain();
        rd(M2, 32'h0, 32'hFF);
        rd(SR, 32'h3000, 32'hFFFF);
        wr(M1, 8'h10);
        wr(SR, 16'hBEEF);
        rd(SR, 32'h3000, 32'hFFFF);
        wr(M1, 8'h50);
        rd(SR, 32'hBEEF, 32'hFFFF);
        rd(M1, 32'h10, 32'hFF);
        cfg(1, 16'h5000, 16'h6000, 16'h00FF, 8'h0A);
        wr(M2, 8'hA5);
        idle(1);
        req_ch1.hw[5] <= 1'b1;
        idle(10);
        pairs(1, 1, 8'h0A);
        req_ch1.in_full <= 1'b1;
        drain();
        cfg(0, 16'h7000, 16'h7100, 16'h00FF, 8'h0A);
        wr(M2, 8'h81);
        cfg(1, 16'h7200, 16'h7300, 16'h00FF, 8'h0A);
        wr(M2, 8'h81);
        pairs(0, 1, 8'h0A);
        pairs(1, 1, 8'h0A);
        idle(1);
        req_ch0.hw[1] <= 1'b1;
        req_ch1.hw[1] <= 1'b1;
        drain();
        cfg(0, 16'h8000, 16'h8100, 16'h0001, 8'h8A);
        cpu.in_isr <= 1'b1;
        wr(M2, 8'h90);
        idle(10);
        wr(M2, 8'hC0);
        cpu.in_isr <= 1'b0;
        idle(10);
        pairs(0, 2, 8'h8A);
        wr(M2, 8'h90);
        drain();
        cfg(0, 16'h9000, 16'h9100, 16'h0001, 8'h8A);
        cpu.irq_pending <= 1'b1;
        pairs(0, 2, 8'h8A);
        wr(M2, 8'h90);
        drain();
        rd(`TCDMA_IDX_STAT, 32'h1, 32'h3);
        cpu.irq_pending <= 1'b0;
        req_ch0.hw[1] <= 1'b0;
        req_ch1.hw[1] <= 1'b0;
        cfg(0, 16'hA000, 16'hA100, 16'h00FF, 8'h0A);
        wr(M2, 8'h81);
        cfg(1, 16'hB000, 16'hB100, 16'h0003, 8'h8A);
        wr(M2, 8'h80);
        pairs(1, 1, 8'h8A);
        pairs(0, 1, 8'h0A);
        pairs(1, 3, 8'h8A);
        wr(M2, 8'h90);
        req_ch0.hw[1] <= 1'b1;
        drain();
        results();
    end
endmodule

/* hw/tcdma.sv */
// Decided for this implementation: the Avalon-MM register port.
`include "tcdma_map.svh"
module tcdma (
    input  wire logic                       clock,
    input  wire logic                       resetn,
    input  wire logic [9:0]                 avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [3:0]                 avs_byteenable,
    input  wire logic [31:0]                avs_writedata,
    output logic [31:0]                     avs_readdata,
    output logic                            avs_waitrequest,
    input  tcdma_pkg::tcdma_src_type        req_ch0,
    input  tcdma_pkg::tcdma_src_type        req_ch1,
    input  tcdma_pkg::tcdma_cpu_type        cpu,
    input  wire logic [7:0]                 mem_rdata,
    output tcdma_pkg::tcdma_mem_req_type    mem_req,
    output logic                            cpu_hold
);
    tcdma_pkg::tcdma_regs_type q;
    tcdma_pkg::tcdma_regs_type n;
    logic [1:0] gq;
    logic [1:0] en;
    logic [1:0] burst;
    logic [1:0] rdy;
    logic [1:0] sw_set;
    logic [1:0] sw_clr;
    logic       irq_cut;
    logic [7:0] idx;
    logic       wr8;
    logic       h;

    function automatic logic [15:0] step(input logic [15:0] a, input logic e, input logic dir);
        if (!e) begin
            step = a;
        end else if (dir) begin
            step = a - 16'h0001;
        end else begin
            step = a + 16'h0001;
        end
    endfunction

    function automatic logic gated(input logic [3:0] code, input logic gate,
                                   input tcdma_pkg::tcdma_src_type s);
        gated = (code != `TCDMA_CODE_OFF) && s.hw[code];
        if (gate && code >= `TCDMA_SENT_LO && code <= `TCDMA_SENT_HI) begin
            gated = gated && s.in_full;
        end else if (gate && code >= `TCDMA_RECV_LO && code <= `TCDMA_RECV_HI) begin
            gated = gated && s.out_empty;
        end
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // Gated source levels per channel
    assign gq[0]   = gated(q.m2[0][3:0], q.m2[0][`TCDMA_M2_GATE], req_ch0);
    assign gq[1]   = gated(q.m2[1][3:0], q.m2[1][`TCDMA_M2_GATE], req_ch1);
    assign en      = {q.m2[1][`TCDMA_M2_EN], q.m2[0][`TCDMA_M2_EN]};
    assign burst   = {q.m1[1][`TCDMA_M1_BURST], q.m1[0][`TCDMA_M1_BURST]};
    assign rdy     = en & (q.cap | q.paused) & ~(burst & {2{cpu.in_isr}});
    assign irq_cut = cpu.irq_pending & ~cpu.irq_masked;
    assign idx     = avs_address[9:2];
    assign wr8     = avs_write & avs_byteenable[0];
    assign h       = q.ch;
    assign sw_set  = (wr8 && idx == `TCDMA_IDX_MODE2 && avs_writedata[`TCDMA_M2_SWT])
                     ? (q.sel ? 2'b10 : 2'b01) : 2'b00;
    assign sw_clr  = (wr8 && idx == `TCDMA_IDX_MODE2 && avs_writedata[`TCDMA_M2_CCLR])
                     ? (q.sel ? 2'b10 : 2'b01) : 2'b00;

    always_comb begin
        n = q;
        n.rdone = 1'b0;
        n.reqd = gq;
        if (avs_write && idx == `TCDMA_IDX_STAT) begin
            n.sfi = q.sfi & ~avs_writedata[1:0];
        end
        case (q.st)
            tcdma_pkg::ST_IDLE: begin
                if (q.give1 && q.paused[1] && rdy[1]) begin
                    n.ch = 1'b1;
                    n.give1 = 1'b0;
                    n.st = tcdma_pkg::ST_READ;
                end else if (rdy[0]) begin
                    n.ch = 1'b0;
                    n.st = tcdma_pkg::ST_READ;
                end else if (rdy[1]) begin
                    n.ch = 1'b1;
                    n.st = tcdma_pkg::ST_READ;
                end
                if (n.st == tcdma_pkg::ST_READ) begin
                    n.cap[n.ch] = 1'b0;
                    n.paused[n.ch] = 1'b0;
                end
            end
            tcdma_pkg::ST_READ: begin
                n.data = mem_rdata;
                n.st = tcdma_pkg::ST_WRITE;
            end
            tcdma_pkg::ST_WRITE: begin
                n.st = tcdma_pkg::ST_GAP;
                n.src[h] = step(q.src[h], q.m1[h][`TCDMA_M1_SEN], q.m1[h][`TCDMA_M1_SDIR]);
                n.dst[h] = step(q.dst[h], q.m1[h][`TCDMA_M1_DEN], q.m1[h][`TCDMA_M1_DDIR]);
                n.cnt[h] = q.cnt[h] - 16'h0001;
                if (q.cnt[h] == 16'h0000) begin
                    n.src[h] = q.rsrc[h];
                    n.dst[h] = q.rdst[h];
                    n.cnt[h] = q.rcnt[h];
                    if (q.m1[h][`TCDMA_M1_ADIS]) begin
                        n.m2[h][`TCDMA_M2_EN] = 1'b0;
                    end
                    if (!h && burst[0] && q.paused[1]) begin
                        n.give1 = 1'b1;
                    end
                end else if (burst[h]) begin
                    if (irq_cut) begin
                        n.sfi[h] = 1'b1;
                        n.paused[h] = 1'b1;
                    end else if (h && en[0] && q.cap[0]) begin
                        n.paused[1] = 1'b1;
                    end else begin
                        n.st = tcdma_pkg::ST_READ;
                    end
                end
            end
            default: begin
                n.st = tcdma_pkg::ST_IDLE;
            end
        endcase
        for (int c = 0; c < 2; c++) begin
            if (sw_clr[c]) begin
                n.cap[c] = 1'b0;
            end
            if ((gq[c] && !q.reqd[c]) || sw_set[c]) begin
                n.cap[c] = 1'b1;
            end
        end
        if (wr8 && idx == `TCDMA_IDX_MODE1) begin
            n.m1[q.sel] = avs_writedata[7:0] & `TCDMA_M1_WMASK;
            if (avs_writedata[`TCDMA_M1_RLD]) begin
                n.src[q.sel] = q.rsrc[q.sel];
                n.dst[q.sel] = q.rdst[q.sel];
                n.cnt[q.sel] = q.rcnt[q.sel];
            end
        end else if (wr8 && idx == `TCDMA_IDX_MODE2) begin
            n.m2[q.sel] = avs_writedata[7:0] & `TCDMA_M2_WMASK;
        end else if (wr8 && idx == `TCDMA_IDX_SEL) begin
            n.sel = avs_writedata[0];
        end else if (avs_write && idx == `TCDMA_IDX_SRC) begin
            n.rsrc[q.sel] = merge16(q.rsrc[q.sel], avs_writedata, avs_byteenable);
            if (!q.m1[q.sel][`TCDMA_M1_LWR]) begin
                n.src[q.sel] = merge16(q.src[q.sel], avs_writedata, avs_byteenable);
            end
        end else if (avs_write && idx == `TCDMA_IDX_DST) begin
            n.rdst[q.sel] = merge16(q.rdst[q.sel], avs_writedata, avs_byteenable);
            if (!q.m1[q.sel][`TCDMA_M1_LWR]) begin
                n.dst[q.sel] = merge16(q.dst[q.sel], avs_writedata, avs_byteenable);
            end
        end else if (avs_write && idx == `TCDMA_IDX_CNT) begin
            n.rcnt[q.sel] = merge16(q.rcnt[q.sel], avs_writedata, avs_byteenable);
            if (!q.m1[q.sel][`TCDMA_M1_LWR]) begin
                n.cnt[q.sel] = merge16(q.cnt[q.sel], avs_writedata, avs_byteenable);
            end
        end
        if (avs_read && !q.rdone) begin
            n.rdone = 1'b1;
            if (idx == `TCDMA_IDX_MODE1) begin
                n.rdata = {24'h000000, q.m1[q.sel]};
            end else if (idx == `TCDMA_IDX_MODE2) begin
                n.rdata = {24'h000000, q.m2[q.sel]};
            end else if (idx == `TCDMA_IDX_SEL) begin
                n.rdata = {31'h00000000, q.sel};
            end else if (idx == `TCDMA_IDX_SRC) begin
                n.rdata = {16'h0000, q.src[q.sel]};
            end else if (idx == `TCDMA_IDX_DST) begin
                n.rdata = {16'h0000, q.dst[q.sel]};
            end else if (idx == `TCDMA_IDX_CNT) begin
                n.rdata = {16'h0000, q.cnt[q.sel]};
            end else if (idx == `TCDMA_IDX_STAT) begin
                n.rdata = {26'h0000000, q.ch, cpu_hold, q.paused, q.sfi};
            end else begin
                n.rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Bus stolen in any cycle of a pair
    assign cpu_hold        = (q.st == tcdma_pkg::ST_READ) || (q.st == tcdma_pkg::ST_WRITE);
    assign mem_req.rd      = (q.st == tcdma_pkg::ST_READ);
    assign mem_req.wr      = (q.st == tcdma_pkg::ST_WRITE);
    assign mem_req.addr    = mem_req.rd ? q.src[h] : q.dst[h];
    assign mem_req.wdata   = q.data;
    assign avs_readdata    = q.rdata;
    assign avs_waitrequest = avs_read & ~q.rdone;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    chk_cpu_gap: assert property ($fell(cpu_hold) |=> !cpu_hold)
        else $error("cpu got less than the minimum gap");
    chk_ch0_first: assert property (
        q.st == tcdma_pkg::ST_IDLE && rdy == 2'b11 && !q.give1 |=> q.st == tcdma_pkg::ST_READ && !q.ch)
        else $error("channel 1 served before channel 0");
    chk_isr_burst: assert property (
        q.st == tcdma_pkg::ST_IDLE && cpu.in_isr |=> !(q.st == tcdma_pkg::ST_READ && burst[q.ch]))
        else $error("burst started during service routine");
    chk_irq_flag: assert property (
        q.st == tcdma_pkg::ST_WRITE && burst[h] && q.cnt[h] != 16'h0000 && irq_cut
        |=> q.sfi[$past(q.ch)] && q.paused[$past(q.ch)] && q.st == tcdma_pkg::ST_GAP)
        else $error("interrupt pause not flagged");
    chk_ch1_yield: assert property (
        q.st == tcdma_pkg::ST_WRITE && h && burst[1] && q.cnt[1] != 16'h0000 && !irq_cut && en[0] && q.cap[0]
        |=> q.paused[1] ##1 q.st == tcdma_pkg::ST_IDLE)
        else $error("channel 1 burst did not yield");
    chk_read_write: assert property (
        mem_req.rd |=> mem_req.wr && mem_req.wdata == $past(mem_rdata))
        else $error("read not followed by its write");
    chk_reload_bit: assert property (
        wr8 && idx == `TCDMA_IDX_MODE1 && avs_writedata[6] && q.st != tcdma_pkg::ST_WRITE
        |=> q.cnt[$past(q.sel)] == q.rcnt[$past(q.sel)] && !q.m1[$past(q.sel)][6])
        else $error("reload bit did not reload");
    chk_disabled_idle: assert property (
        q.st == tcdma_pkg::ST_IDLE && en == 2'b00 |=> q.st != tcdma_pkg::ST_READ)
        else $error("disabled channel started");

    cov_preempt: cover property (q.paused[1] ##[1:4] (q.st == tcdma_pkg::ST_READ && !q.ch));
    cov_irq_pause: cover property ($rose(q.sfi[0]) || $rose(q.sfi[1]));
    cov_give_one: cover property ($rose(q.give1) ##[1:4] (q.st == tcdma_pkg::ST_READ && q.ch));
endmodule

/* hw/tcdma_map.svh */
`ifndef TCDMA_MAP_SVH
`define TCDMA_MAP_SVH
`define TCDMA_IDX_MODE1 8'h40
`define TCDMA_IDX_MODE2 8'h41
`define TCDMA_IDX_SEL   8'h42
`define TCDMA_IDX_SRC   8'h43
`define TCDMA_IDX_DST   8'h44
`define TCDMA_IDX_CNT   8'h45
`define TCDMA_IDX_STAT  8'h46
`define TCDMA_M1_SDIR   0
`define TCDMA_M1_SEN    1
`define TCDMA_M1_DDIR   2
`define TCDMA_M1_DEN    3
`define TCDMA_M1_LWR    4
`define TCDMA_M1_ADIS   5
`define TCDMA_M1_RLD    6
`define TCDMA_M1_BURST  7
`define TCDMA_M2_SWT    4
`define TCDMA_M2_GATE   5
`define TCDMA_M2_CCLR   6
`define TCDMA_M2_EN     7
`define TCDMA_M1_WMASK  8'hBF
`define TCDMA_M2_WMASK  8'hAF
`define TCDMA_CODE_OFF  4'h0
`define TCDMA_SENT_LO   4'h5
`define TCDMA_SENT_HI   4'h7
`define TCDMA_RECV_LO   4'h8
`define TCDMA_RECV_HI   4'hB
`endif

/* hw/tcdma_pkg.sv */
package tcdma_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10,
        ST_GAP   = 2'b11
    } tcdma_state_type;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } tcdma_mem_req_type;

    typedef struct packed {
        logic irq_pending;
        logic irq_masked;
        logic in_isr;
    } tcdma_cpu_type;

    typedef struct packed {
        logic [15:0] hw;
        logic        out_empty;
        logic        in_full;
    } tcdma_src_type;

    typedef struct packed {
        tcdma_state_type  st;
        logic             ch;
        logic [1:0][7:0]  m1;
        logic [1:0][7:0]  m2;
        logic             sel;
        logic [1:0][15:0] src;
        logic [1:0][15:0] dst;
        logic [1:0][15:0] cnt;
        logic [1:0][15:0] rsrc;
        logic [1:0][15:0] rdst;
        logic [1:0][15:0] rcnt;
        logic [1:0]       cap;
        logic [1:0]       reqd;
        logic [1:0]       paused;
        logic [1:0]       sfi;
        logic             give1;
        logic [7:0]       data;
        logic             rdone;
        logic [31:0]      rdata;
    } tcdma_regs_type;
endpackage
